// >>> core/rtc_access_pkg.sv
// Purpose: constants for the clock indirect access control block
// Assumes: 8-bit special function register bus, 100 MHz system clock
// Notes:   offsets are byte addresses on the special function register bus
package rtc_access_pkg;
   localparam logic [7:0] ADDR_CTRL_OFS  = 8'hAC;
   localparam logic [7:0] ADDR_DATA_OFS  = 8'hAD;
   localparam int         BUSY_POS       = 7;
   localparam int         AUTO_POS       = 6;
   localparam int         VREG_POS       = 5;
   localparam int         FAST_POS       = 4;
   localparam int         SEL_MSB        = 3;
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] DATA_RESET     = 8'h00;
   localparam logic [2:0] STROBE_LONG    = 3'h4;
   localparam logic [2:0] STROBE_SHORT   = 3'h1;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } xfer_state_t;
endpackage

// >>> core/strobe_timer.sv
// Purpose: times one indirect strobe into the clock domain
// Assumes: start pulses only while idle
// Notes:   width 4 cycles, or 1 with fast timing
module strobe_timer
(
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic start_in,
   input  wire logic fast_in,
   output logic      active_out,
   output logic      done_out
);
   import rtc_access_pkg::*;

   logic [2:0] count_r;
   logic [2:0] count_nxt;
   logic [2:0] load_val;

   assign load_val  = fast_in ? STROBE_SHORT : STROBE_LONG;
   assign count_nxt = start_in ? load_val :
                      (count_r != 3'h0) ? count_r - 3'h1 : 3'h0;
   assign active_out = (count_r != 3'h0);
   assign done_out   = (count_r == 3'h1);

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_r <= 3'h0;
      end else begin
         count_r <= count_nxt;
      end
   end
endmodule

// >>> core/rtc_indirect_access_control.sv
// Purpose: indirect access control register into the clock's internal registers
// Assumes: processor writes/reads registers with one-cycle strobes
// Notes:   clock internal registers live outside; this block drives strobes
module rtc_indirect_access_control
(
   input  wire logic       ref_clk_in,
   input  wire logic       arst_n_in,
   input  wire logic [7:0] sfr_addr_in,
   input  wire logic [7:0] sfr_wdata_in,
   input  wire logic       sfr_wr_in,
   input  wire logic       sfr_rd_in,
   input  wire logic       backup_above_main_in,
   input  wire logic [7:0] rtc_rdata_in,
   output logic [7:0]      sfr_rdata_out,
   output logic            rtc_rd_strobe_out,
   output logic            rtc_wr_strobe_out,
   output logic [3:0]      rtc_index_out,
   output logic [7:0]      rtc_wdata_out,
   output logic            backup_regulator_on_out
);
   import rtc_access_pkg::*;

   // ==========================================================
   // reset release
   logic rst_meta_r;
   logic rst_n_r;
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ==========================================================
   // decode
   logic ctrl_wr;
   logic data_wr;
   logic data_rd;
   logic ctrl_rd;
   logic idle;
   logic start_rd;
   logic start_wr;
   xfer_state_t state_r;
   xfer_state_t state_nxt;
   logic        tmr_active;
   logic        tmr_done;

   assign ctrl_wr = sfr_wr_in && (sfr_addr_in == ADDR_CTRL_OFS);
   assign data_wr = sfr_wr_in && (sfr_addr_in == ADDR_DATA_OFS);
   assign ctrl_rd = sfr_rd_in && (sfr_addr_in == ADDR_CTRL_OFS);
   assign data_rd = sfr_rd_in && (sfr_addr_in == ADDR_DATA_OFS);
   assign idle    = (state_r == ST_IDLE);

   // ==========================================================
   // control register fields
   logic       auto_read_enable_r;
   logic       backup_regulator_enable_r;
   logic       fast_timing_r;
   logic [3:0] sel_index_r;
   logic [7:0] data_r;

   // data read rearms read when auto read is enabled
   // data writes and busy starts during a transfer are dropped, control fields still update; the strobe already in flight wins
   assign start_rd = idle && ((ctrl_wr && sfr_wdata_in[BUSY_POS]) ||
                              (data_rd && auto_read_enable_r));
   assign start_wr = idle && data_wr;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_wr) begin
               state_nxt = ST_WRITE;
            end else if (start_rd) begin
               state_nxt = ST_READ;
            end
         end
         ST_READ: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (tmr_done) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   strobe_timer u_timer (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_r),
      .start_in   (start_rd || start_wr),
      .fast_in    (fast_timing_r),
      .active_out (tmr_active),
      .done_out   (tmr_done)
   );

   always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         auto_read_enable_r        <= CTRL_RESET[AUTO_POS];
         backup_regulator_enable_r <= CTRL_RESET[VREG_POS];
         fast_timing_r             <= CTRL_RESET[FAST_POS];
         sel_index_r               <= CTRL_RESET[SEL_MSB:0];
      end else begin
         if (ctrl_wr) begin
            auto_read_enable_r <= sfr_wdata_in[AUTO_POS];
            fast_timing_r      <= sfr_wdata_in[FAST_POS];
            sel_index_r        <= sfr_wdata_in[SEL_MSB:0];
         end
         if (backup_above_main_in) begin
            backup_regulator_enable_r <= 1'b1;
         end else if (ctrl_wr) begin
            backup_regulator_enable_r <= sfr_wdata_in[VREG_POS];
         end
      end
   end

   // read data captured at end of indirect read
   always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         data_r <= DATA_RESET;
      end else if (start_wr) begin
         data_r <= sfr_wdata_in;
      end else if ((state_r == ST_READ) && tmr_done) begin
         data_r <= rtc_rdata_in;
      end
   end

   // ==========================================================
   // outputs, all registered
   logic [7:0] ctrl_view;
   logic [7:0] rdata_nxt;
   logic       busy_nxt;

   assign busy_nxt  = (state_nxt != ST_IDLE);
   assign ctrl_view = {busy_nxt, auto_read_enable_r, backup_regulator_enable_r,
                       fast_timing_r, sel_index_r};
   assign rdata_nxt = ctrl_rd ? ctrl_view : (data_rd ? data_r : 8'h00);

   always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sfr_rdata_out           <= 8'h00;
         rtc_rd_strobe_out       <= 1'b0;
         rtc_wr_strobe_out       <= 1'b0;
         rtc_index_out           <= 4'h0;
         rtc_wdata_out           <= 8'h00;
         backup_regulator_on_out <= 1'b0;
      end else begin
         sfr_rdata_out <= rdata_nxt;
         rtc_rd_strobe_out <= (state_nxt == ST_READ);
         rtc_wr_strobe_out <= (state_nxt == ST_WRITE);
         rtc_index_out <= ctrl_wr && idle ? sfr_wdata_in[SEL_MSB:0] : sel_index_r;
         if (start_wr) begin
            rtc_wdata_out <= sfr_wdata_in;
         end
         backup_regulator_on_out <= backup_regulator_enable_r || backup_above_main_in;
      end
   end

   // ==========================================================
   // checks
   property p_busy_start;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (idle && ctrl_wr && sfr_wdata_in[BUSY_POS] && !data_wr) |=> rtc_rd_strobe_out;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy write gave no read");

   property p_long;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (start_rd && !start_wr && !fast_timing_r) |=> rtc_rd_strobe_out [*4] ##1 !rtc_rd_strobe_out;
   endproperty
   a_long: assert property (p_long) else $error("long strobe not four cycles");

   property p_short;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (start_rd && !start_wr && fast_timing_r) |=> rtc_rd_strobe_out ##1 !rtc_rd_strobe_out;
   endproperty
   a_short: assert property (p_short) else $error("short strobe not one cycle");

   property p_clear;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      !idle |-> ##[1:4] idle;
   endproperty
   a_clear: assert property (p_clear) else $error("busy did not clear");

   property p_busy_view;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      ctrl_rd |=> (sfr_rdata_out[BUSY_POS] == !idle);
   endproperty
   a_busy_view: assert property (p_busy_view) else $error("busy read wrong");

   property p_force;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      backup_above_main_in |=> backup_regulator_on_out && backup_regulator_enable_r;
   endproperty
   a_force: assert property (p_force) else $error("regulator not forced");

   property p_off;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (!backup_regulator_enable_r && !backup_above_main_in) |=> !backup_regulator_on_out;
   endproperty
   a_off: assert property (p_off) else $error("regulator on while disabled");

   property p_auto;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (idle && data_rd && auto_read_enable_r) |=> rtc_rd_strobe_out;
   endproperty
   a_auto: assert property (p_auto) else $error("auto read not started");

   property p_index;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (rtc_rd_strobe_out && $past(rtc_rd_strobe_out)) |-> (rtc_index_out == sel_index_r);
   endproperty
   a_index: assert property (p_index) else $error("index mismatch");

   property p_layout;
      @(posedge ref_clk_in) disable iff (!rst_n_r)
      (idle && ctrl_wr && !sfr_wdata_in[BUSY_POS] && !backup_above_main_in) |=>
         (ctrl_view[6:0] == $past(sfr_wdata_in[6:0]));
   endproperty
   a_layout: assert property (p_layout) else $error("field layout wrong");
endmodule

// >>> tb/rtc_regs_model.sv
// Purpose: far-side model of the clock internal registers
// Assumes: strobes and index come from the access control block
// Notes:   idle data toggles every cycle so stale captures show up
module rtc_regs_model (
   input  wire logic       ref_clk_in,
   input  wire logic       rd_strobe_in,
   input  wire logic       wr_strobe_in,
   input  wire logic [3:0] index_in,
   input  wire logic [7:0] wdata_in,
   output logic [7:0]      rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem_r [16];
   logic [7:0] pat_r = 8'h5A;
   always @(posedge ref_clk_in) begin
      pat_r <= ~pat_r;
      if (wr_strobe_in) begin
         mem_r[index_in] <= wdata_in;
      end
   end
   assign rdata_out = rd_strobe_in ? mem_r[index_in] : pat_r;
endmodule

// >>> tb/tb_rtc_indirect_access_control.sv
// Purpose: self-checking bench for the indirect access control block
// Assumes: data register at the package offset, strobes from one clock
// Notes:   driver queues expectations, negedge monitor compares them
module tb_rtc_indirect_access_control;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_access_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        bk_above = 1'b0;
   logic        rd_seen = 1'b0;
   logic [7:0]  sfr_rdata, rtc_rdata, rtc_wdata, v;
   logic        rd_stb, wr_stb, vreg_on;
   logic [3:0]  idx, i;
   logic [2:0]  w;
   logic [6:0]  e;
   logic [31:0] lfsr = 32'hBD4504AB;
   logic [7:0]  exp_q[$];
   logic [6:0]  stb_q[$];
   int          error_cnt = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          run = 0;

   always #5 clk = ~clk;

   rtc_indirect_access_control dut (
      .ref_clk_in(clk), .arst_n_in(arst_n), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
      .sfr_wr_in(wr), .sfr_rd_in(rd), .backup_above_main_in(bk_above),
      .rtc_rdata_in(rtc_rdata), .sfr_rdata_out(sfr_rdata), .rtc_rd_strobe_out(rd_stb),
      .rtc_wr_strobe_out(wr_stb), .rtc_index_out(idx), .rtc_wdata_out(rtc_wdata),
      .backup_regulator_on_out(vreg_on));

   rtc_regs_model regs (
      .ref_clk_in(clk), .rd_strobe_in(rd_stb), .wr_strobe_in(wr_stb),
      .index_in(idx), .wdata_in(rtc_wdata), .rdata_out(rtc_rdata));

   // ==========================================
   // helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string name, input logic [7:0] ex, input logic [7:0] s);
      n_checks++;
      if (s !== ex) begin
         $display("ERROR %s expected %h seen %h", name, ex, s);
         error_cnt++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // idle cycle after each request, so no strobe is set twice in one step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] ex);
      exp_q.push_back(ex);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      tick(1);
   endtask
   task automatic end_sim;
      // notes left over mean a result never showed up
      if (exp_q.size() != 0 || stb_q.size() != 0) begin
         $display("ERROR pending notes expected 0 seen %0d", exp_q.size() + stb_q.size());
         error_cnt++;
      end
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================
   // monitor: read data and strobe runs
   always @(posedge clk) begin
      rd_seen <= rd;
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   always @(negedge clk) begin
      if (rd_seen) begin
         chk("read data", exp_q.pop_front(), sfr_rdata);
      end
      if (rd_stb | wr_stb) begin
         run++;
      end else if (run > 0) begin
         e = stb_q.pop_front();
         chk("strobe width", {5'h00, e[2:0]}, run[7:0]);
         chk("index", {4'h0, e[6:3]}, {4'h0, idx});
         run = 0;
      end
   end

   // ==========================================
   // stimulus
   initial begin
      tick(12);
      arst_n <= 1'b1;
      tick(3);
      rd_reg(ADDR_CTRL_OFS, CTRL_RESET);
      rd_reg(8'h00, 8'h00);
      $display("test reset done");
      for (int f = 0; f < 2; f++) begin
         v = lfsr[7:0];
         lfsr = lfsr_next(lfsr);
         i = f ? 4'h5 : 4'h3;
         w = f ? STROBE_SHORT : STROBE_LONG;
         wr_reg(ADDR_CTRL_OFS, {3'b000, f[0], i});
         stb_q.push_back({i, w});
         wr_reg(ADDR_DATA_OFS, v);
         tick(5);
         stb_q.push_back({i, w});
         wr_reg(ADDR_CTRL_OFS, {3'b100, f[0], i});
         rd_reg(ADDR_CTRL_OFS, f ? {4'h1, i} : {4'h8, i});
         tick(5);
         rd_reg(ADDR_CTRL_OFS, {3'b000, f[0], i});
         rd_reg(ADDR_DATA_OFS, v);
         $display("test timing %0d done", f);
      end
      wr_reg(ADDR_CTRL_OFS, 8'h45);
      stb_q.push_back({4'h5, STROBE_LONG});
      wr_reg(ADDR_CTRL_OFS, 8'hC5);
      tick(5);
      for (int k = 0; k < 2; k++) begin
         stb_q.push_back({4'h5, STROBE_LONG});
         rd_reg(ADDR_DATA_OFS, v);
         tick(5);
      end
      wr_reg(ADDR_CTRL_OFS, 8'h05);
      rd_reg(ADDR_DATA_OFS, v);
      tick(5);
      $display("test auto read done");
      bk_above <= 1'b1;
      tick(2);
      chk("regulator", 8'h01, {7'h00, vreg_on});
      rd_reg(ADDR_CTRL_OFS, 8'h25);
      bk_above <= 1'b0;
      wr_reg(ADDR_CTRL_OFS, 8'h05);
      // output follows the cleared enable one edge after the write lands
      tick(1);
      chk("regulator", 8'h00, {7'h00, vreg_on});
      rd_reg(ADDR_CTRL_OFS, 8'h05);
      $display("test regulator done");
      tick(2);
      end_sim();
   end
endmodule
